// *** dv/sdd_chk_properties.sv ***
// sdd_chk_properties: timing checks on the link between host and dac
// assumes one clock, clk_in, and a synchronous active high reset
module sdd_chk import sdd_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic shift_strobe_a,
  input wire logic shift_strobe_b,
  input wire logic shift_strobe_c,
  input wire logic shift_strobe_d,
  input wire logic dac_load_a,
  input wire logic dac_load_b,
  input wire logic dac_register_zero
);
  logic [3:0] stb_r, stb_nxt, chg;
  logic [5:0] gap_r, gap_nxt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // strobe moves and cycles since the last move
  always_comb begin
    stb_nxt = {shift_strobe_d, shift_strobe_c, shift_strobe_b, shift_strobe_a};
    chg = stb_nxt ^ stb_r;
    gap_nxt = (chg != 4'h0) ? 6'h00 : gap_r + {5'h00, gap_r != 6'h3f};
    gap_nxt = rst_in ? 6'h3f : gap_nxt;
  end
  always_ff @(posedge clk_in) begin
    stb_r <= stb_nxt;
    gap_r <= gap_nxt;
  end
  AST_STROBE_GROUP: assert property (chg != 4'h0 |-> $onehot(chg) || chg == 4'hf)
    else $error("several strobes moved");
  AST_HALF_WIDTH: assert property ($onehot(chg) |-> gap_r >= 6'd18)
    else $error("strobe level too short");
  AST_DATA_HOLD: assert property ($changed(serial_data_in) && gap_r < 6'd18 |-> chg != 4'h0)
    else $error("data moved after strobe");
  AST_SRO_QUIET: assert property ($changed(serial_data_out) |-> gap_r <= 6'd6)
    else $error("serial out moved without strobe");
  AST_LOADS_PAIR: assert property (dac_load_a == dac_load_b)
    else $error("loads differ");
  AST_LOAD_QUIET: assert property (dac_load_a && $past(dac_load_a) |-> chg == 4'h0)
    else $error("strobe moved during load");
  AST_LOAD_AFTER_EDGE: assert property ($rose(dac_load_a) |-> gap_r == 6'd0)
    else $error("load not right after last strobe move");
  AST_LOAD_WIDTH: assert property ($rose(dac_load_a) |-> ##19 dac_load_a ##[1:2] !dac_load_a)
    else $error("load width wrong");
  cover property ($rose(dac_load_a));
  cover property (chg == 4'hf);
  cover property ($rose(dac_register_zero));
  cover property ($changed(serial_data_out));
endmodule // sdd_chk

// *** dv/tb_top.sv ***
// tb_top: host and dac joined over the link, random and corner words
// assumes the dac serial out returns straight to the host
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdd_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, clear_in = 1'b0;
  logic rise_h = 1'b1, rise_d = 1'b1, busy, done, shift_ev;
  logic [1:0] sel_h = 2'h0, sel_d = 2'h0;
  logic [11:0] word_in = 12'h000, held = 12'h000, dac_exp = 12'h000, back, dac_val;
  int fails = 0, cmp_count = 0, cyc = 0, ev_total = 0, i;
  integer seed = 32'h830b, v;
  sdd_link_if link();
  sdd_host u_sdd_host (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
    .word_in(word_in), .strobe_sel_in(sel_h), .strobe_rise_in(rise_h), .clear_in(clear_in),
    .busy_out(busy), .done_out(done), .word_back_out(back), .link(link));
  sdd_dac u_sdd_dac (.clk_in(clk_in), .rst_in(rst_in), .link(link), .strobe_sel_in(sel_d),
    .strobe_rise_in(rise_d), .dac_value_out(dac_val), .shift_event_out(shift_ev));
  sdd_chk u_sdd_chk (.clk_in(clk_in), .rst_in(rst_in), .serial_data_in(link.serial_data_in),
    .serial_data_out(link.serial_data_out), .shift_strobe_a(link.shift_strobe_a),
    .shift_strobe_b(link.shift_strobe_b), .shift_strobe_c(link.shift_strobe_c),
    .shift_strobe_d(link.shift_strobe_d), .dac_load_a(link.dac_load_a),
    .dac_load_b(link.dac_load_b), .dac_register_zero(link.dac_register_zero));
  // clock
  always #2 clk_in = ~clk_in;
  // old word read back: whole word, or its msb repeated when not shifting
  function automatic logic [11:0] expect_back(input logic m, input logic [11:0] h);
    return m ? h : {12{h[11]}};
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one word over the link, then compare both ends
  task automatic xfer(input logic [11:0] w, input logic [1:0] sh, sd, input logic r, c);
    int t0, k;
    logic m;
    m = (sh == sd);
    t0 = ev_total;
    word_in = w; sel_h = sh; sel_d = sd; rise_h = r; rise_d = r; clear_in = c;
    start_in = 1'b1;
    @(posedge clk_in);
    #1 start_in = 1'b0;
    `CHK("busy", 1'b1, busy)
    k = 0;
    do begin @(posedge clk_in); #1; k++; end while (done !== 1'b1 && k < 700);
    `CHK("done", 1'b1, done)
    `CHK("idle", 1'b0, busy)
    `CHK("back", expect_back(m, held), back)
    `CHK("events", m ? 12 : 0, ev_total - t0)
    if (m) held = w;
    dac_exp = c ? 12'h000 : held;
    repeat (4) @(posedge clk_in);
    #1 `CHK("dac", dac_exp, dac_val)
  endtask
  // shift events and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (shift_ev === 1'b1) ev_total <= ev_total + 1;
    if (cyc == 20000) begin fails++; summarize(); end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    xfer(12'hfff, 2'h0, 2'h0, 1'b1, 1'b0);
    xfer(12'h801, 2'h1, 2'h1, 1'b0, 1'b0);
    xfer(12'h5a3, 2'h2, 2'h2, 1'b1, 1'b1);
    xfer(12'h000, 2'h3, 2'h1, 1'b0, 1'b0);
    for (i = 0; i < 10; i++) begin
      v = $random(seed);
      xfer(v[11:0], v[13:12], v[13:12], v[14], 1'b0);
    end
    summarize();
  end
endmodule // tb_top

// *** verilog/sdd_dac.sv ***
// sdd_dac: dac end, shift register with daisy output and dac register
// assumes link pins are asynchronous to clk_in and synchronised here
// Behaviour
// (R1) take twelve bits in, msb first
// (R2) old word shifts out msb first
// (R3) shift on chosen strobe edge polarity
// (R4) both loads copy shift word to dac
// (R5) host shares data, strobe, load lines
// (R6) clear zeroes dac register, keeps shift
module sdd_dac import sdd_pkg::*; #(
  parameter int WIDTH = WORD_BITS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link
  sdd_link_if.dac link,
  // user side
  input wire logic [1:0] strobe_sel_in,
  input wire logic strobe_rise_in,
  output logic [WIDTH-1:0] dac_value_out,
  output logic shift_event_out
);
  logic [8:0] s1_r;
  logic [8:0] s2_r;
  logic [8:0] sync_nxt;
  logic strobe_prev_r;
  logic strobe_prev_nxt;
  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] shift_nxt;
  logic [WIDTH-1:0] dac_r;
  logic [WIDTH-1:0] dac_nxt;
  logic sro_r;
  logic sro_nxt;
  logic ev_r;
  logic ev_nxt;
  logic strobe_now;
  logic active_edge;
  // two-stage synchroniser inputs
  always_comb begin
    sync_nxt = {link.dac_register_zero, link.dac_load_b, link.dac_load_a,
                link.shift_strobe_d, link.shift_strobe_c, link.shift_strobe_b,
                link.shift_strobe_a, link.serial_data_in, 1'b0};
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= sync_nxt;
      s2_r <= s1_r;
    end
  end
  // chosen strobe and edge
  always_comb begin
    unique case (strobe_sel_in)
      STB_SEL_A: strobe_now = s2_r[2];
      STB_SEL_B: strobe_now = s2_r[3];
      STB_SEL_C: strobe_now = s2_r[4];
      STB_SEL_D: strobe_now = s2_r[5];
    endcase
    // (R3) edge polarity select
    active_edge = strobe_rise_in ? (strobe_now & ~strobe_prev_r)
                                 : (~strobe_now & strobe_prev_r);
  end
  // shift, load and clear
  always_comb begin
    strobe_prev_nxt = strobe_now;
    shift_nxt = shift_r;
    dac_nxt = dac_r;
    sro_nxt = sro_r;
    ev_nxt = 1'b0;
    if (active_edge) begin
      // (R1) msb first shift in
      shift_nxt = {shift_r[WIDTH-2:0], s2_r[1]};
      // (R2) next old bit out
      sro_nxt = shift_r[WIDTH-2];
      ev_nxt = 1'b1;
    end else begin
      sro_nxt = shift_r[WIDTH-1];
    end
    // (R4) both loads copy
    if (s2_r[6] && s2_r[7]) begin
      dac_nxt = shift_r;
    end
    // (R6) clear wins, shift kept
    if (s2_r[8]) begin
      dac_nxt = '0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      strobe_prev_r <= 1'b0;
      shift_r <= '0;
      dac_r <= '0;
      sro_r <= 1'b0;
      ev_r <= 1'b0;
    end else begin
      strobe_prev_r <= strobe_prev_nxt;
      shift_r <= shift_nxt;
      dac_r <= dac_nxt;
      sro_r <= sro_nxt;
      ev_r <= ev_nxt;
    end
  end
  assign link.serial_data_out = sro_r;
  assign dac_value_out = dac_r;
  assign shift_event_out = ev_r;
endmodule : sdd_dac

// *** verilog/sdd_host.sv ***
// sdd_host: host end, shifts a word out, reads old word back, loads
// assumes serial_data_out returns asynchronously and is synchronised here
module sdd_host import sdd_pkg::*; #(
  parameter int WIDTH = WORD_BITS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // user side
  input wire logic start_in,
  input wire logic [WIDTH-1:0] word_in,
  input wire logic [1:0] strobe_sel_in,
  input wire logic strobe_rise_in,
  input wire logic clear_in,
  output logic busy_out,
  output logic done_out,
  output logic [WIDTH-1:0] word_back_out,
  // link
  sdd_link_if.host link
);
  sdd_state_type st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [WIDTH-1:0] tx_r, tx_nxt, rx_r, rx_nxt, back_r, back_nxt;
  logic stb_r, stb_nxt, data_r, data_nxt, load_r, load_nxt, clr_r, clr_nxt;
  logic done_r, done_nxt, busy_r, busy_nxt, rise_r, rise_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic ret1_r, ret2_r;
  // sequencer: half period inactive strobe level, half active level per bit
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    back_nxt = back_r;
    stb_nxt = stb_r;
    data_nxt = data_r;
    load_nxt = 1'b0;
    clr_nxt = clear_in;
    done_nxt = 1'b0;
    sel_nxt = sel_r;
    rise_nxt = rise_r;
    unique case (st_r)
      SDD_IDLE: begin
        stb_nxt = ~rise_r;
        if (start_in) begin
          tx_nxt = word_in;
          sel_nxt = strobe_sel_in;
          rise_nxt = strobe_rise_in;
          stb_nxt = ~strobe_rise_in;
          // (R1) msb presented first
          data_nxt = word_in[WIDTH-1];
          bit_nxt = 5'h00;
          cnt_nxt = 8'h00;
          st_nxt = SDD_LOW;
        end
      end
      SDD_LOW: begin
        if (cnt_r == 8'(STROBE_HALF_CYC - 1)) begin
          // (R3) active edge of strobe
          stb_nxt = rise_r;
          cnt_nxt = 8'h00;
          rx_nxt = {rx_r[WIDTH-2:0], ret2_r};
          tx_nxt = {tx_r[WIDTH-2:0], 1'b0};
          st_nxt = SDD_HIGH;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      SDD_HIGH: begin
        if (cnt_r == 8'(STROBE_HALF_CYC - 1)) begin
          stb_nxt = ~rise_r;
          cnt_nxt = 8'h00;
          data_nxt = tx_r[WIDTH-1];
          if (bit_r == 5'(WIDTH - 1)) begin
            st_nxt = SDD_LOAD;
          end else begin
            bit_nxt = bit_r + 5'h01;
            st_nxt = SDD_LOW;
          end
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      SDD_LOAD: begin
        // (R4) both loads after full word
        load_nxt = 1'b1;
        if (cnt_r == 8'(LOAD_CYC - 1)) begin
          // last load cycle, loads stand LOAD_CYC cycles in all
          st_nxt = SDD_DONE;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      SDD_DONE: begin
        back_nxt = rx_r;
        done_nxt = 1'b1;
        st_nxt = SDD_IDLE;
      end
      default: st_nxt = SDD_IDLE;
    endcase
    busy_nxt = (st_nxt != SDD_IDLE);
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= SDD_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      back_r <= '0;
      stb_r <= 1'b0;
      data_r <= 1'b0;
      load_r <= 1'b0;
      clr_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      sel_r <= STB_SEL_A;
      rise_r <= 1'b1;
      ret1_r <= 1'b0;
      ret2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      back_r <= back_nxt;
      stb_r <= stb_nxt;
      data_r <= data_nxt;
      load_r <= load_nxt;
      clr_r <= clr_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      sel_r <= sel_nxt;
      rise_r <= rise_nxt;
      ret1_r <= link.serial_data_out;
      ret2_r <= ret1_r;
    end
  end
  // (R5) one data, strobe and load drive
  assign link.serial_data_in = data_r;
  assign link.shift_strobe_a = (sel_r == STB_SEL_A) ? stb_r : ~rise_r;
  assign link.shift_strobe_b = (sel_r == STB_SEL_B) ? stb_r : ~rise_r;
  assign link.shift_strobe_c = (sel_r == STB_SEL_C) ? stb_r : ~rise_r;
  assign link.shift_strobe_d = (sel_r == STB_SEL_D) ? stb_r : ~rise_r;
  assign link.dac_load_a = load_r;
  assign link.dac_load_b = load_r;
  assign link.dac_register_zero = clr_r;
  assign busy_out = busy_r;
  assign done_out = done_r;
  assign word_back_out = back_r;
endmodule : sdd_host

// *** verilog/sdd_link_if.sv ***
// sdd_link_if: wires between host and dac end
// assumes the bench connects dac serial_data_out back or to another dac
interface sdd_link_if;
  logic serial_data_in;
  logic serial_data_out;
  logic shift_strobe_a;
  logic shift_strobe_b;
  logic shift_strobe_c;
  logic shift_strobe_d;
  logic dac_load_a;
  logic dac_load_b;
  logic dac_register_zero;
  modport dac (
    input serial_data_in, shift_strobe_a, shift_strobe_b, shift_strobe_c,
    input shift_strobe_d, dac_load_a, dac_load_b, dac_register_zero,
    output serial_data_out
  );
  modport host (
    output serial_data_in, shift_strobe_a, shift_strobe_b, shift_strobe_c,
    output shift_strobe_d, dac_load_a, dac_load_b, dac_register_zero,
    input serial_data_out
  );
endinterface : sdd_link_if

// *** verilog/sdd_pkg.sv ***
// sdd_pkg: shared constants for the daisy-chain dac serial link
// assumes both ends run on one 250 mhz clock, clk_in
package sdd_pkg;
  // word and timing
  localparam int WORD_BITS = 12;
  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_HALF_NS = 80;
  localparam int STROBE_HALF_CYC = (STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_NS = 80;
  localparam int LOAD_CYC = (LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe selection codes
  localparam logic [1:0] STB_SEL_A = 2'h0;
  localparam logic [1:0] STB_SEL_B = 2'h1;
  localparam logic [1:0] STB_SEL_C = 2'h2;
  localparam logic [1:0] STB_SEL_D = 2'h3;
  // host sequencer states
  typedef enum logic [4:0] {
    SDD_IDLE = 5'h01,
    SDD_LOW = 5'h02,
    SDD_HIGH = 5'h04,
    SDD_LOAD = 5'h08,
    SDD_DONE = 5'h10
  } sdd_state_type;
endpackage : sdd_pkg
